// ### verilog/brg_glue.sv
// reset generator, interrupt button debouncer and memory-area glue
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - reset output stays low while the supply is out of tolerance
// - after supply recovers, reset stays low another 350 ms
// - reset button is debounced; on release a 350 ms reset follows
// - interrupt line goes low on first closure, stays low until release
// - interrupt line idles high so a reset press gives power-on reset
// - program rom is area 0 from address 0, always whole words
// - static ram sits in area 2 starting at 800000 hex
// - ram reads whole words; upper and lower write strobes per byte
// - led latch captures on any write within area 1
// - led latch takes data bits 8 to 15, the upper byte
module brg_glue #(
   parameter int STRETCH_CYCLES  = int'(brg_pkg::STRETCH_CYCLES),
   parameter int DEBOUNCE_CYCLES = int'(brg_pkg::DEBOUNCE_CYCLES)
) (
   // clock and reset
   input  wire logic                         i_mclk,
   input  wire logic                         i_srst,
   // supervisor and buttons
   input  wire logic                         i_supply_ok,
   input  wire logic                         i_reset_button,
   input  wire logic                         i_interrupt_button_make,
   input  wire logic                         i_interrupt_button_break,
   // to the core
   output logic                              o_reset_n,
   output logic                              o_nmi_n,
   // core bus
   input  wire logic [brg_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic                         i_area0_select_n,
   input  wire logic                         i_area1_select_n,
   input  wire logic                         i_area2_select_n,
   input  wire logic                         i_rd_n,
   input  wire logic                         i_upper_byte_write_n,
   input  wire logic                         i_lower_byte_write_n,
   input  wire logic [brg_pkg::DATA_W-1:0]   i_data,
   output logic      [brg_pkg::DATA_W-1:0]   o_data,
   output logic                              o_data_oe_n,
   // program rom
   output logic                              o_rom_select_n,
   output logic      [brg_pkg::RAM_AW-1:0]   o_rom_addr,
   input  wire logic [brg_pkg::DATA_W-1:0]   i_rom_data,
   // led latch
   output logic      [brg_pkg::LED_W-1:0]    o_led
);
   ////////////////////////////////////////////////////////////////////////
   // button synchronisers
   logic rbtn_s1, rbtn_s2, make_s1, make_s2, brk_s1, brk_s2;

   always_ff @(posedge i_mclk) begin
      rbtn_s1 <= i_reset_button;
      rbtn_s2 <= rbtn_s1;
      make_s1 <= i_interrupt_button_make;
      make_s2 <= make_s1;
      brk_s1  <= i_interrupt_button_break;
      brk_s2  <= brk_s1;
   end

   ////////////////////////////////////////////////////////////////////////
   // reset button debounce
   logic                          rbtn_deb, next_rbtn_deb;
   logic [brg_pkg::DEBOUNCE_W-1:0] deb_cnt, next_deb_cnt;

   always_comb begin
      next_rbtn_deb = rbtn_deb;
      next_deb_cnt  = '0;
      if (rbtn_s2 != rbtn_deb) begin
         if (deb_cnt == brg_pkg::DEBOUNCE_W'(DEBOUNCE_CYCLES - 1)) begin
            next_rbtn_deb = rbtn_s2;
         end else begin
            next_deb_cnt = deb_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rbtn_deb <= 1'b0;
         deb_cnt  <= '0;
      end else begin
         rbtn_deb <= next_rbtn_deb;
         deb_cnt  <= next_deb_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset generator
   brg_pkg::brg_rst_state_type      rst_state, next_rst_state;
   logic [brg_pkg::STRETCH_W-1:0]   str_cnt, next_str_cnt;
   logic                            next_reset_n;
   logic                            str_done;

   assign str_done = (rst_state == brg_pkg::RS_STRETCH) &&
      (str_cnt == brg_pkg::STRETCH_W'(STRETCH_CYCLES - 1));

   always_comb begin
      next_rst_state = rst_state;
      next_str_cnt   = str_cnt;
      if (!i_supply_ok || rbtn_deb) begin
         next_rst_state = brg_pkg::RS_HOLD;
         next_str_cnt   = '0;
      end else begin
         case (rst_state)
            brg_pkg::RS_HOLD: begin
               next_rst_state = brg_pkg::RS_STRETCH;
               next_str_cnt   = '0;
            end
            brg_pkg::RS_STRETCH: begin
               if (str_done) begin
                  next_rst_state = brg_pkg::RS_RUN;
               end else begin
                  next_str_cnt = str_cnt + 1'b1;
               end
            end
            brg_pkg::RS_RUN: begin
               next_rst_state = brg_pkg::RS_RUN;
            end
            default: begin
               next_rst_state = brg_pkg::RS_HOLD;
               next_str_cnt   = '0;
            end
         endcase
      end
      next_reset_n = (next_rst_state == brg_pkg::RS_RUN);
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rst_state <= brg_pkg::RS_HOLD;
         str_cnt   <= '0;
         o_reset_n <= 1'b0;
      end else begin
         rst_state <= next_rst_state;
         str_cnt   <= next_str_cnt;
         o_reset_n <= next_reset_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt button set-reset latch
   logic next_nmi_n;

   always_comb begin
      next_nmi_n = o_nmi_n;
      if (make_s2 && !brk_s2) begin
         next_nmi_n = 1'b0;
      end else if (brk_s2 && !make_s2) begin
         next_nmi_n = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_nmi_n <= 1'b1;
      end else begin
         o_nmi_n <= next_nmi_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memory areas
   logic                          wr_hi_q, wr_lo_q;
   logic                          we_hi, we_lo, ram_hit, led_we;
   logic                          rd_rom, rd_ram;
   logic [1:0]                    ram_we;
   logic [brg_pkg::DATA_W-1:0]    ram_rdata, rom_q;
   logic                          sel_rom_q, rd_q;
   logic [brg_pkg::DATA_W-1:0]    next_data;
   logic [brg_pkg::LED_W-1:0]     next_led;

   // rom is word wide from address zero, byte address bit ignored
   assign o_rom_select_n = i_area0_select_n;
   assign o_rom_addr     = i_addr[brg_pkg::RAM_AW:1];

   assign ram_hit = !i_area2_select_n &&
      (i_addr[brg_pkg::ADDR_W-1:brg_pkg::RAM_TAG_LSB] ==
       brg_pkg::RAM_BASE[brg_pkg::ADDR_W-1:brg_pkg::RAM_TAG_LSB]);
   // one write per strobe fall
   assign we_hi  = !i_upper_byte_write_n && wr_hi_q;
   assign we_lo  = !i_lower_byte_write_n && wr_lo_q;
   assign ram_we = {we_hi && ram_hit, we_lo && ram_hit};
   assign led_we = !i_area1_select_n && (we_hi || we_lo);
   assign rd_rom = !i_area0_select_n && !i_rd_n;
   assign rd_ram = ram_hit && !i_rd_n;

   brg_word_ram u_ram (
      .i_mclk  (i_mclk),
      .i_addr  (i_addr[brg_pkg::RAM_AW:1]),
      .i_byte_we(ram_we),
      .i_wdata (i_data),
      .o_rdata (ram_rdata)
   );

   always_comb begin
      next_data = sel_rom_q ? rom_q : ram_rdata;
      next_led  = o_led;
      if (led_we) begin
         next_led = i_data[brg_pkg::LED_LSB +: brg_pkg::LED_W];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         wr_hi_q     <= 1'b1;
         wr_lo_q     <= 1'b1;
         rom_q       <= '0;
         sel_rom_q   <= 1'b0;
         rd_q        <= 1'b0;
         o_data      <= '0;
         o_data_oe_n <= 1'b1;
         o_led       <= brg_pkg::LED_RESET;
      end else begin
         wr_hi_q     <= i_upper_byte_write_n;
         wr_lo_q     <= i_lower_byte_write_n;
         rom_q       <= i_rom_data;
         sel_rom_q   <= rd_rom;
         rd_q        <= rd_rom || rd_ram;
         o_data      <= next_data;
         o_data_oe_n <= !rd_q;
         o_led       <= next_led;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_SUPPLY_HOLD: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      !i_supply_ok |=> !o_reset_n)
      else $error("reset released while supply bad");
   AST_STRETCH_END: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      $rose(o_reset_n) |-> $past(str_done))
      else $error("reset released before stretch end");
   AST_BUTTON_HOLD: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      rbtn_deb |=> !o_reset_n ##1 !o_reset_n)
      else $error("reset released while button held");
   AST_NMI_MAKE: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      $rose(make_s2) && !brk_s2 |=> !o_nmi_n)
      else $error("interrupt line not low on closure");
   AST_NMI_BOUNCE: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      !o_nmi_n && !brk_s2 |=> !o_nmi_n)
      else $error("interrupt line rose before release");
   AST_NMI_IDLE: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      brk_s2 && !make_s2 |=> o_nmi_n)
      else $error("interrupt line not high at rest");
   AST_LED_CAPTURE: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      led_we |=> o_led == $past(i_data[15:8]))
      else $error("led latch missed upper byte");
   AST_LED_HOLD: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      !led_we |=> $stable(o_led))
      else $error("led latch changed without area 1 write");
   AST_READ_DRIVE: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      (rd_rom || rd_ram) |=> ##1 !o_data_oe_n)
      else $error("read not answered on data bus");
   AST_RAM_AREA: assert property (
      @(posedge i_mclk) disable iff (i_srst)
      (|ram_we) |-> !i_area2_select_n && i_addr[23] && !i_addr[22])
      else $error("ram written outside area 2 base");

   COV_RESET_RELEASE: cover property (@(posedge i_mclk) $rose(o_reset_n));
   COV_NMI_FALL: cover property (@(posedge i_mclk) $fell(o_nmi_n));
   COV_LED_WRITE: cover property (@(posedge i_mclk) led_we);
   COV_RAM_UPPER: cover property (@(posedge i_mclk) ram_we == 2'b10);
endmodule
`default_nettype wire

// ### verilog/brg_pkg.sv
// constants and types shared by the board reset, interrupt and memory glue
`default_nettype none
package brg_pkg;
   // clock and timing
   localparam longint CLK_HZ         = 64'd20_000_000;
   localparam longint STRETCH_MS     = 64'd350;
   localparam longint STRETCH_CYCLES =
      (STRETCH_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam longint DEBOUNCE_MS    = 64'd10;
   localparam longint DEBOUNCE_CYCLES =
      (DEBOUNCE_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam int     STRETCH_W      = 23;
   localparam int     DEBOUNCE_W     = 18;

   // memory map
   localparam int           ADDR_W      = 24;
   localparam int           DATA_W      = 16;
   localparam int           RAM_AW      = 16;
   localparam logic [23:0]  RAM_BASE    = 24'h800000;
   localparam int           RAM_TAG_LSB = 17;
   localparam int           LED_W       = 8;
   localparam int           LED_LSB     = 8;
   localparam logic [7:0]   LED_RESET   = 8'h00;

   // reset generator states
   typedef enum logic [2:0] {
      RS_HOLD    = 3'b001,
      RS_STRETCH = 3'b010,
      RS_RUN     = 3'b100
   } brg_rst_state_type;
endpackage
`default_nettype wire

// ### verilog/brg_word_ram.sv
// word-organised static ram with byte write enables and registered read
`timescale 1ns/1ps
`default_nettype none
module brg_word_ram (
   // clock
   input  wire logic                         i_mclk,
   // access
   input  wire logic [brg_pkg::RAM_AW-1:0]   i_addr,
   input  wire logic [1:0]                   i_byte_we,
   input  wire logic [brg_pkg::DATA_W-1:0]   i_wdata,
   output logic      [brg_pkg::DATA_W-1:0]   o_rdata
);
   // each byte lane keeps its own array so the lanes never share a driver
   genvar lane;
   generate
      for (lane = 0; lane < 2; lane++) begin : g_lane
         logic [7:0] mem [0:(1<<brg_pkg::RAM_AW)-1];
         logic [7:0] rd_q;

         always_ff @(posedge i_mclk) begin
            if (i_byte_we[lane]) begin
               mem[i_addr] <= i_wdata[lane*8 +: 8];
            end
            rd_q <= mem[i_addr];
         end
      end
   endgenerate

   // read is always the whole word
   assign o_rdata = {g_lane[1].rd_q, g_lane[0].rd_q};
endmodule
`default_nettype wire

// ### verif/brg_core_model.sv
// behavioural core bus master that also records the kind of each reset
`timescale 1ns/1ps
`default_nettype none
module brg_core_model (
   // clock and core reset inputs
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   input  wire logic        i_nmi_n,
   // external bus
   output logic      [23:0] o_addr,
   output logic      [2:0]  o_sel_n,
   output logic             o_rd_n,
   output logic      [1:0]  o_wr_n,
   output logic      [15:0] o_wdata,
   input  wire logic [15:0] i_rdata,
   // high when the last reset release was a manual reset
   output logic             o_manual,
   // falling interrupt edges taken while the core runs
   output logic      [7:0]  o_nmi_count
);
   logic reset_q = 1'b0;
   logic nmi_q   = 1'b1;

   initial begin
      o_addr = 24'h000000;
      o_sel_n = 3'h7;
      o_rd_n = 1'b1;
      o_wr_n = 2'h3;
      o_wdata = 16'h0000;
      o_manual = 1'b0;
      o_nmi_count = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt line level at the reset rise picks the reset kind
   // a manual reset keeps bus and port setup; the flag tells the bench so
   always @(posedge i_mclk) begin
      reset_q <= i_reset_n;
      nmi_q   <= i_nmi_n;
      if (i_reset_n && !reset_q) begin
         o_manual <= !i_nmi_n;
      end
      // edges during reset are dropped
      if (i_reset_n && nmi_q && !i_nmi_n) begin
         o_nmi_count <= o_nmi_count + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // waits are chosen per area by the caller
   task automatic write(input logic [2:0] sel_n, input logic [23:0] addr,
                        input logic [15:0] data, input logic [1:0] wr_n,
                        input int waits);
      @(posedge i_mclk);
      o_addr <= addr;
      o_sel_n <= sel_n;
      o_wdata <= data;
      o_wr_n <= wr_n;
      repeat (waits + 1) @(posedge i_mclk);
      o_sel_n <= 3'h7;
      o_wr_n <= 2'h3;
      o_wdata <= ~data;
      @(posedge i_mclk);
   endtask

   // whole words only; waits must be at least 2
   task automatic read(input logic [2:0] sel_n, input logic [23:0] addr,
                       input int waits, output logic [15:0] data);
      @(posedge i_mclk);
      o_addr <= addr;
      o_sel_n <= sel_n;
      o_rd_n <= 1'b0;
      repeat (waits + 1) @(posedge i_mclk);
      data = i_rdata;
      o_sel_n <= 3'h7;
      o_rd_n <= 1'b1;
      @(posedge i_mclk);
   endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the board reset, interrupt and memory glue
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
   end \
end
module tb;
   localparam int STRETCH  = 20;
   localparam int DEBOUNCE = 4;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        supply_ok = 1'b1;
   logic        rst_btn = 1'b0;
   logic        make = 1'b0;
   logic        brk = 1'b1;
   logic        reset_n, nmi_n, rd_n, data_oe_n, rom_sel_n, manual;
   logic [2:0]  sel_n;
   logic [1:0]  wr_n;
   logic [23:0] addr;
   logic [15:0] wdata, rdata, rom_addr, rom_data, d;
   logic [7:0]  led, nmi_count;
   int          errors = 0;
   int          checked = 0;
   int          n;

   // rom answers only while selected
   assign rom_data = rom_sel_n ? 16'hFFFF : rom_addr ^ 16'hC3C3;
   always #25 mclk = ~mclk;

   brg_glue #(
      .STRETCH_CYCLES(STRETCH), .DEBOUNCE_CYCLES(DEBOUNCE)
   ) brg_glue_i (
      .i_mclk(mclk), .i_srst(srst), .i_supply_ok(supply_ok),
      .i_reset_button(rst_btn), .i_interrupt_button_make(make),
      .i_interrupt_button_break(brk), .o_reset_n(reset_n), .o_nmi_n(nmi_n),
      .i_addr(addr), .i_area0_select_n(sel_n[0]),
      .i_area1_select_n(sel_n[1]), .i_area2_select_n(sel_n[2]),
      .i_rd_n(rd_n), .i_upper_byte_write_n(wr_n[1]),
      .i_lower_byte_write_n(wr_n[0]), .i_data(wdata), .o_data(rdata),
      .o_data_oe_n(data_oe_n), .o_rom_select_n(rom_sel_n),
      .o_rom_addr(rom_addr), .i_rom_data(rom_data), .o_led(led));

   brg_core_model brg_core_model_i (
      .i_mclk(mclk), .i_reset_n(reset_n), .i_nmi_n(nmi_n), .o_addr(addr),
      .o_sel_n(sel_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wdata(wdata),
      .i_rdata(rdata), .o_manual(manual), .o_nmi_count(nmi_count));

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // edges after the last drive until the core reset reaches lvl
   task automatic wait_rst(input logic lvl, input int bound);
      n = 0;
      while (reset_n !== lvl && n < bound) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= bound) begin
         errors++;
         test_done();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_supply();
      @(posedge mclk);
      supply_ok <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      `CHK(reset_n, 1'b0)
      @(posedge mclk);
      supply_ok <= 1'b1;
      repeat (STRETCH / 2) @(posedge mclk);
      supply_ok <= 1'b0;
      @(posedge mclk);
      supply_ok <= 1'b1;
      wait_rst(1'b1, 200);
      `CHK(n >= STRETCH + 1 && n <= STRETCH + 3, 1'b1)
   endtask

   task automatic t_button();
      @(posedge mclk);
      rst_btn <= 1'b1;
      @(posedge mclk);
      rst_btn <= 1'b0;
      @(posedge mclk);
      rst_btn <= 1'b1;
      wait_rst(1'b0, DEBOUNCE + 20);
      `CHK(n >= DEBOUNCE + 1, 1'b1)
      repeat (30) @(posedge mclk);
      rst_btn <= 1'b0;
      @(posedge mclk);
      rst_btn <= 1'b1;
      @(posedge mclk);
      rst_btn <= 1'b0;
      wait_rst(1'b1, STRETCH + DEBOUNCE + 40);
      `CHK(n >= STRETCH + DEBOUNCE, 1'b1)
      repeat (2) @(posedge mclk);
      #1;
      `CHK(manual, 1'b0)
   endtask

   task automatic t_nmi();
      @(posedge mclk);
      make <= 1'b1;
      brk <= 1'b0;
      @(posedge mclk);
      #1;
      `CHK(nmi_n, 1'b1)
      repeat (2) @(posedge mclk);
      #1;
      `CHK(nmi_n, 1'b0)
      make <= 1'b0;
      @(posedge mclk);
      make <= 1'b1;
      @(posedge mclk);
      make <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      `CHK(nmi_n, 1'b0)
      brk <= 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      `CHK(nmi_n, 1'b1)
      `CHK(nmi_count, 8'h01)
   endtask

   task automatic t_manual();
      @(posedge mclk);
      rst_btn <= 1'b1;
      wait_rst(1'b0, DEBOUNCE + 20);
      make <= 1'b1;
      brk <= 1'b0;
      repeat (6) @(posedge mclk);
      rst_btn <= 1'b0;
      wait_rst(1'b1, STRETCH + DEBOUNCE + 40);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(manual, 1'b1)
      `CHK(nmi_count, 8'h01)
      make <= 1'b0;
      brk <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask

   task automatic t_mem();
      brg_core_model_i.read(3'b110, 24'h000246, 3, d);
      `CHK(d, 16'h0123 ^ 16'hC3C3)
      #1;
      `CHK(data_oe_n, 1'b0)
      @(posedge mclk);
      #1;
      `CHK(data_oe_n, 1'b1)
      brg_core_model_i.write(3'b011, 24'h800010, 16'hABCD, 2'b00, 3);
      brg_core_model_i.write(3'b011, 24'h800010, 16'h5566, 2'b01, 3);
      brg_core_model_i.write(3'b011, 24'h800010, 16'h7788, 2'b10, 6);
      brg_core_model_i.write(3'b011, 24'h820010, 16'hFFFF, 2'b00, 3);
      brg_core_model_i.write(3'b011, 24'h81FFFE, 16'h0F0F, 2'b00, 3);
      brg_core_model_i.read(3'b011, 24'h800010, 6, d);
      `CHK(d, 16'h5588)
      brg_core_model_i.read(3'b011, 24'h81FFFE, 3, d);
      `CHK(d, 16'h0F0F)
      brg_core_model_i.write(3'b101, 24'h400123, 16'hA55A, 2'b00, 3);
      `CHK(led, 8'hA5)
      brg_core_model_i.write(3'b101, 24'h7FFFFE, 16'h3CC3, 2'b00, 3);
      `CHK(led, 8'h3C)
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      #1;
      `CHK(led, 8'h00)
      wait_rst(1'b1, 200);
      `CHK(nmi_n, 1'b1)
      t_supply();
      t_button();
      t_nmi();
      t_manual();
      t_mem();
      test_done();
   end
endmodule
`default_nettype wire
